//--- hms_pkg.sv
package hms_pkg;

    // Entry timing, in system clock cycles
    localparam int unsigned XCLK_LOW_MIN   = 32;
    localparam int unsigned XCLK_LOW_MAX   = 45;
    localparam logic [6:0]  XCLK_LOW_CYC   = 7'h26;
    localparam logic [6:0]  FLUSH_SHORT    = 7'h10;
    localparam logic [6:0]  FLUSH_MID      = 7'h20;
    localparam logic [6:0]  FLUSH_LONG     = 7'h40;
    localparam logic [2:0]  WAKE_HOLDOFF   = 3'h4;

    // Exit timing
    localparam int unsigned LOCK_CYCLES_DEF = 131072;
    localparam int unsigned LOCK_CNT_W      = 18;
    localparam logic [10:0] RESUME_FLASH    = 11'h465;
    localparam logic [10:0] RESUME_RAM      = 11'h023;

    // Reset values of the clock controls
    localparam logic        CLK_RUN_RST     = 1'b1;

    typedef enum logic [2:0] {
        HMS_RUN,
        HMS_ENTRY,
        HMS_HALT,
        HMS_OSC_WAIT,
        HMS_LOCK,
        HMS_RESUME
    } hms_state_t;

    typedef struct packed {
        logic external_clock_output;
        logic system_clock_output;
        logic core_clock;
        logic peripheral_clock;
        logic pll;
        logic oscillator;
    } hms_clk_ctrl_t;

endpackage : hms_pkg

//--- hms_lock_counter.sv
`timescale 1ns/1ps
module hms_lock_counter
    import hms_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic clk_en,
    input  wire logic clear,
    input  wire logic run,
    output logic      done
);
    localparam logic [LOCK_CNT_W-1:0] TERMINAL = LOCK_CNT_W'(LOCK_CYCLES - 1);

    logic [LOCK_CNT_W-1:0] count;
    logic [LOCK_CNT_W-1:0] next_count;
    logic                  at_terminal;

    assign at_terminal = (count == TERMINAL);
    assign next_count  = clear ? '0 : count + LOCK_CNT_W'(1);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count <= '0;
            done  <= 1'b0;
        end else if (clk_en) begin
            if (clear || (run && !done)) begin
                count <= next_count;
            end
            done <= !clear && (done || (run && at_terminal));
        end
    end

endmodule : hms_lock_counter

//--- hms_sequencer.sv
`timescale 1ns/1ps
module hms_sequencer
    import hms_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF
) (
    input  wire logic          core_clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    input  wire logic          halt_idle_exec,
    input  wire logic [1:0]    clock_divide_select,
    input  wire logic          crystal_source,
    input  wire logic          pll_bypass,
    input  wire logic          wake_from_flash,
    input  wire logic          wake_irq_enable,
    input  wire logic          wake_pin,
    input  wire logic          osc_stable,
    output hms_clk_ctrl_t      clk_ctrl,
    output logic               halt_active,
    output logic               exec_resume,
    output logic               wake_irq
);

    hms_state_t  state;
    hms_state_t  next_state;

    logic [6:0]  entry_cnt;
    logic [2:0]  holdoff_cnt;
    logic [10:0] resume_cnt;
    logic        xclk_run;
    logic        sys_run;
    logic        periph_run;
    logic        pll_run;
    logic        osc_run;
    logic        halt_flag;

    logic        wake_s1;
    logic        wake_s2;
    logic        wake_s3;
    logic        stable_s1;
    logic        stable_s2;

    // Flush length and entry timing
    logic [6:0]  flush_len;
    logic        flush_done;
    logic        xclk_hit;
    logic        entry_done;
    logic        holdoff_done;
    logic        wake_fall;
    logic        lock_clear;
    logic        lock_run;
    logic        lock_done;
    logic [10:0] resume_limit;
    logic        resume_done;
    logic        osc_async_on;

    assign flush_len    = (clock_divide_select == 2'h3) ? FLUSH_LONG :
                          (clock_divide_select == 2'h2) ? FLUSH_MID  : FLUSH_SHORT;
    assign flush_done   = (entry_cnt >= flush_len);
    assign xclk_hit     = (entry_cnt == XCLK_LOW_CYC);
    assign entry_done   = flush_done && !xclk_run;
    assign holdoff_done = (holdoff_cnt == WAKE_HOLDOFF);
    assign wake_fall    = wake_s3 && !wake_s2;
    assign lock_clear   = (state == HMS_OSC_WAIT) && stable_s2;
    assign lock_run     = (state == HMS_LOCK);
    assign resume_limit = wake_from_flash ? RESUME_FLASH : RESUME_RAM;
    // Lock flag and state update cost two edges, so stop two short of the limit
    assign resume_done  = (resume_cnt == resume_limit - 11'h002);

    // Pin falling edge restarts the oscillator without any clock
    assign osc_async_on = halt_flag && !wake_pin;

    always_comb begin
        next_state = state;
        unique case (state)
            HMS_RUN: begin
                if (halt_idle_exec) begin
                    next_state = HMS_ENTRY;
                end
            end
            HMS_ENTRY: begin
                if (entry_done) begin
                    next_state = HMS_HALT;
                end
            end
            HMS_HALT: begin
                if (wake_fall && holdoff_done) begin
                    next_state = HMS_OSC_WAIT;
                end
            end
            HMS_OSC_WAIT: begin
                if (stable_s2) begin
                    next_state = HMS_LOCK;
                end
            end
            HMS_LOCK: begin
                if (lock_done) begin
                    next_state = HMS_RESUME;
                end
            end
            HMS_RESUME: begin
                if (resume_done) begin
                    next_state = HMS_RUN;
                end
            end
        endcase
    end

    // Two-stage synchronisers for the pin and the oscillator status
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wake_s1   <= 1'b1;
            wake_s2   <= 1'b1;
            wake_s3   <= 1'b1;
            stable_s1 <= 1'b0;
            stable_s2 <= 1'b0;
        end else if (clk_en) begin
            wake_s1   <= wake_pin;
            wake_s2   <= wake_s1;
            wake_s3   <= wake_s2;
            stable_s1 <= osc_stable;
            stable_s2 <= stable_s1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= HMS_RUN;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Entry and hold-off counters
    always_ff @(posedge core_clk) begin
        if (srst) begin
            entry_cnt   <= '0;
            holdoff_cnt <= '0;
        end else if (clk_en) begin
            if (state == HMS_RUN) begin
                entry_cnt   <= halt_idle_exec ? 7'h01 : 7'h00;
                holdoff_cnt <= halt_idle_exec ? 3'h1 : 3'h0;
            end else begin
                if (state == HMS_ENTRY && !entry_done) begin
                    entry_cnt <= entry_cnt + 7'h01;
                end
                if (!holdoff_done) begin
                    holdoff_cnt <= holdoff_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            resume_cnt <= '0;
        end else if (clk_en) begin
            resume_cnt <= (state == HMS_RESUME) ? resume_cnt + 11'h001 : 11'h000;
        end
    end

    // Clock gating controls
    always_ff @(posedge core_clk) begin
        if (srst) begin
            xclk_run   <= CLK_RUN_RST;
            sys_run    <= CLK_RUN_RST;
            periph_run <= CLK_RUN_RST;
            pll_run    <= CLK_RUN_RST;
            osc_run    <= CLK_RUN_RST;
            halt_flag  <= 1'b0;
        end else if (clk_en) begin
            if (state == HMS_ENTRY && xclk_hit) begin
                xclk_run <= 1'b0;
            end
            if (state == HMS_ENTRY && flush_done) begin
                sys_run <= 1'b0;
            end
            if (state == HMS_ENTRY && entry_done) begin
                periph_run <= 1'b0;
                pll_run    <= 1'b0;
                osc_run    <= !crystal_source;
                halt_flag  <= 1'b1;
            end
            if (state == HMS_HALT && next_state == HMS_OSC_WAIT) begin
                osc_run   <= 1'b1;
                halt_flag <= 1'b0;
            end
            if (state == HMS_OSC_WAIT && stable_s2) begin
                pll_run <= 1'b1;
            end
            if (state == HMS_LOCK && lock_done) begin
                sys_run    <= 1'b1;
                periph_run <= 1'b1;
                xclk_run   <= 1'b1;
            end
        end
    end

    // Resume and interrupt pulses
    always_ff @(posedge core_clk) begin
        if (srst) begin
            exec_resume <= 1'b0;
            wake_irq    <= 1'b0;
        end else if (clk_en) begin
            exec_resume <= (state == HMS_RESUME) && resume_done;
            wake_irq    <= (state == HMS_RESUME) && resume_done && wake_irq_enable;
        end
    end

    hms_lock_counter #(
        .LOCK_CYCLES (LOCK_CYCLES)
    ) u_lock (
        .core_clk (core_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .clear    (lock_clear),
        .run      (lock_run),
        .done     (lock_done)
    );

    // Lock wait runs whatever the bypass; bypass only keeps the PLL off
    assign clk_ctrl.external_clock_output = xclk_run;
    assign clk_ctrl.system_clock_output   = sys_run;
    assign clk_ctrl.core_clock            = sys_run;
    assign clk_ctrl.peripheral_clock      = periph_run;
    assign clk_ctrl.pll                   = pll_run && !pll_bypass;
    assign clk_ctrl.oscillator            = osc_run || osc_async_on;
    assign halt_active                    = halt_flag;

endmodule : hms_sequencer

//--- hms_sequencer_props.sv
`timescale 1ns/1ps
module hms_sequencer_props
    import hms_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF
) (
    input wire logic          core_clk,
    input wire logic          srst,
    input wire logic          halt_idle_exec,
    input wire logic [1:0]    clock_divide_select,
    input wire logic          crystal_source,
    input wire logic          wake_from_flash,
    input wire logic          wake_irq_enable,
    input wire logic          wake_pin,
    input wire logic          osc_stable,
    input wire hms_clk_ctrl_t clk_ctrl,
    input wire logic          halt_active,
    input wire logic          exec_resume,
    input wire logic          wake_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    logic [7:0]  ent;
    logic [17:0] lk;
    logic [11:0] rs;
    wire  [7:0]  fl  = clock_divide_select[1] ? (clock_divide_select[0] ? 8'h40 : 8'h20) : 8'h10;
    wire  [11:0] lim = wake_from_flash ? 12'h465 : 12'h023;
    // Cycles since idle, since stable oscillator, since clocks back
    always_ff @(posedge core_clk) begin
        ent <= (srst || halt_idle_exec) ? 8'h01 : ent + {7'h00, ent != 8'hFF};
        lk  <= (srst || !osc_stable || halt_active) ? 18'h00000 : lk + {17'h00000, lk != 18'h3FFFF};
        rs  <= (srst || !clk_ctrl.core_clock) ? 12'h000 : rs + {11'h000, rs != 12'hFFF};
    end
    xclk_low_win_a: assert property ($fell(clk_ctrl.external_clock_output) |-> ent >= 8'h20 && ent <= 8'h2D)
        else $error("external clock low outside window");
    flush_len_a: assert property ($fell(clk_ctrl.system_clock_output) |-> ent >= fl && ent <= fl + 8'h03)
        else $error("flush length wrong");
    halt_gates_a: assert property ($rose(halt_active) |-> !clk_ctrl.peripheral_clock && !clk_ctrl.pll)
        else $error("halt with clocks on");
    osc_halt_a: assert property (halt_active && wake_pin |-> clk_ctrl.oscillator == !crystal_source)
        else $error("oscillator state in halt wrong");
    osc_wake_a: assert property (halt_active && !wake_pin |-> clk_ctrl.oscillator)
        else $error("oscillator not on at wake");
    lock_wait_a: assert property ($rose(clk_ctrl.core_clock) |-> lk >= LOCK_CYCLES && lk <= LOCK_CYCLES + 8)
        else $error("lock wait length wrong");
    resume_lat_a: assert property (exec_resume |-> rs >= lim - 12'h004 && rs < lim && clk_ctrl.peripheral_clock)
        else $error("resume latency wrong");
    irq_pair_a: assert property (wake_irq == (exec_resume && wake_irq_enable))
        else $error("wake interrupt mismatch");
    cover property ($rose(halt_active) && crystal_source);
    cover property (exec_resume && wake_from_flash);
    cover property (wake_irq);
endmodule : hms_sequencer_props

bind hms_sequencer hms_sequencer_props #(.LOCK_CYCLES(LOCK_CYCLES)) hms_sequencer_props_i (
    .core_clk(core_clk), .srst(srst), .halt_idle_exec(halt_idle_exec), .clock_divide_select(clock_divide_select),
    .crystal_source(crystal_source), .wake_from_flash(wake_from_flash), .wake_irq_enable(wake_irq_enable),
    .wake_pin(wake_pin), .osc_stable(osc_stable), .clk_ctrl(clk_ctrl), .halt_active(halt_active),
    .exec_resume(exec_resume), .wake_irq(wake_irq));

//--- hms_wake_model.sv
`timescale 1ns/1ps
module hms_wake_model (
    input  wire logic       core_clk,
    input  wire logic       halt_idle_exec,
    input  wire logic       oscillator,
    input  wire logic       wake_req,
    input  wire logic [3:0] st_dly,
    output logic            wake_pin,
    output logic            osc_stable
);
    logic [3:0] since_idle = 4'h0;
    logic [3:0] st_cnt     = 4'h0;
    initial wake_pin = 1'b1;
    initial osc_stable = 1'b1;
    always @(posedge core_clk) begin
        since_idle <= halt_idle_exec ? 4'h0 : since_idle + {3'h0, since_idle != 4'hF};
        st_cnt <= (oscillator !== 1'b1) ? 4'h0 : st_cnt + {3'h0, st_cnt != 4'hF};
        osc_stable <= (oscillator === 1'b1) && st_cnt >= st_dly;
        if (wake_req && since_idle >= 4'h4) begin
            wake_pin <= 1'b0;
        end else if (osc_stable) begin
            wake_pin <= 1'b1;
        end
    end
endmodule : hms_wake_model

//--- hms_sequencer_tb_top.sv
`timescale 1ns/1ps
module hms_sequencer_tb_top;
    import hms_pkg::*;
    localparam int LK = 16;
    logic          core_clk = 1'b0;
    logic          srst = 1'b1;
    logic          halt_idle_exec = 1'b0;
    logic [1:0]    clock_divide_select = 2'h0;
    logic          crystal_source = 1'b0;
    logic          pll_bypass = 1'b0;
    logic          wake_from_flash = 1'b0;
    logic          wake_irq_enable = 1'b0;
    logic          wake_req = 1'b0;
    logic [3:0]    st_dly = 4'h2;
    logic          wake_pin;
    logic          osc_stable;
    hms_clk_ctrl_t clk_ctrl;
    logic          halt_active;
    logic          exec_resume;
    logic          wake_irq;
    int            num_errors = 0;
    int            checks = 0;
    always #25 core_clk = ~core_clk;
    hms_sequencer #(.LOCK_CYCLES(LK)) hms_sequencer_i (.core_clk(core_clk), .srst(srst), .clk_en(1'b1),
        .halt_idle_exec(halt_idle_exec), .clock_divide_select(clock_divide_select), .crystal_source(crystal_source),
        .pll_bypass(pll_bypass), .wake_from_flash(wake_from_flash), .wake_irq_enable(wake_irq_enable),
        .wake_pin(wake_pin), .osc_stable(osc_stable), .clk_ctrl(clk_ctrl), .halt_active(halt_active),
        .exec_resume(exec_resume), .wake_irq(wake_irq));
    hms_wake_model hms_wake_model_i (.core_clk(core_clk), .halt_idle_exec(halt_idle_exec),
        .oscillator(clk_ctrl.oscillator), .wake_req(wake_req), .st_dly(st_dly), .wake_pin(wake_pin),
        .osc_stable(osc_stable));
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t bit %b exp %b", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("[ERR] %0t count %0d not %0d..%0d", $time, got, lo, hi);
        end
    endtask : cmp_rng
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic t_entry(input logic [1:0] ds, input logic xtal);
        int n;
        int t_x;
        int t_s;
        int fl;
        t_x = 0;
        t_s = 0;
        fl = (ds == 2'h3) ? 64 : (ds == 2'h2) ? 32 : 16;
        @(posedge core_clk);
        clock_divide_select <= ds;
        crystal_source <= xtal;
        halt_idle_exec <= 1'b1;
        @(posedge core_clk);
        halt_idle_exec <= 1'b0;
        for (n = 1; n < 100 && halt_active !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
            if (t_x == 0 && clk_ctrl.external_clock_output === 1'b0) t_x = n;
            if (t_s == 0 && clk_ctrl.system_clock_output === 1'b0) t_s = n;
        end
        cmp_rng(t_x, 32, 45);
        cmp_rng(t_s, fl, fl + 2);
        cmp_bit(clk_ctrl.peripheral_clock | clk_ctrl.pll | clk_ctrl.core_clock, 1'b0);
        cmp_bit(clk_ctrl.oscillator, !xtal);
        $display("t_entry %0d done", ds);
    endtask : t_entry
    task automatic t_wake(input logic fls, input logic ie, input logic byp);
        int n;
        int lim;
        lim = fls ? 1125 : 35;
        @(posedge core_clk);
        wake_from_flash <= fls;
        wake_irq_enable <= ie;
        pll_bypass <= byp;
        wake_req <= 1'b1;
        for (n = 0; n < 20 && wake_pin !== 1'b0; n++) begin
            @(posedge core_clk);
            #1;
        end
        cmp_bit(clk_ctrl.oscillator & !wake_pin, 1'b1);
        @(posedge core_clk);
        wake_req <= 1'b0;
        for (n = 0; n < 40 && osc_stable !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        cmp_bit(osc_stable, 1'b1);
        for (n = 0; n < LK + 40 && clk_ctrl.core_clock !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        cmp_rng(n, LK, LK + 6);
        for (n = 0; n < 1200 && exec_resume !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        // Clocks return one edge after lock, so resume is due one cycle sooner here
        cmp_rng(n, lim - 4, lim - 1);
        cmp_bit(wake_irq, ie);
        cmp_bit(clk_ctrl.peripheral_clock & clk_ctrl.core_clock, 1'b1);
        cmp_bit(clk_ctrl.pll, !byp);
        $display("t_wake %0d done", fls);
    endtask : t_wake
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        #1;
        cmp_bit(&clk_ctrl, 1'b1);
        cmp_bit(halt_active, 1'b0);
        for (int i = 0; i < 4; i++) begin
            st_dly <= (i == 3) ? 4'hC : 4'h2;
            t_entry(i[1:0], i[0]);
            t_wake(i[1], i[0], i == 2);
        end
        tally_and_finish();
    end
    initial begin
        #1000000;
        num_errors++;
        tally_and_finish();
    end
endmodule : hms_sequencer_tb_top
